// File: spc_pad_model.sv
// pad model: resolves each pin from drive, pull-up and the outside world
`timescale 1ns/1ns
`default_nettype none
module spc_pad_model (
    // pad side of the block
    input wire logic [7:0] drive_val_i,
    input wire logic [7:0] drive_en_i,
    input wire logic [7:0] pullup_en_i,
    // outside level where nobody drives; the bench changes it often
    input wire logic [7:0] ext_i,
    // level seen by the block
    output logic [7:0] level_o
);
    // a released pin floats to the outside pattern unless pulled up
    assign level_o = (drive_en_i & drive_val_i) | (~drive_en_i & pullup_en_i)
                   | (~drive_en_i & ~pullup_en_i & ext_i);
endmodule : spc_pad_model
`default_nettype wire

// File: spc_pkg.sv
// shared constants for the serial port pin control block
package spc_pkg;
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_DATA = 8'hD6;
    localparam logic [7:0] IDX_PIN_DIR = 8'hD7;
    localparam logic [7:0] IDX_PULL_DRIVE = 8'hDB;
    localparam logic [7:0] IDX_SERIAL_CTRL = 8'hDC;

    localparam logic [7:0] PIN_DATA_RST = 8'h00;
    localparam logic [7:0] PIN_DIR_RST = 8'h00;
    localparam logic [7:0] PULL_DRIVE_RST = 8'h07;
    localparam logic [7:0] PULL_DRIVE_MASK = 8'h77;
    localparam logic [7:0] SERIAL_CTRL_RST = 8'h00;
    localparam logic [7:0] SERIAL_CTRL_MASK = 8'h3F;

    // pull-up and reduced-drive register fields
    localparam int REDUCE_DRIVE_UPPER_BIT = 6;
    localparam int REDUCE_DRIVE_MIDDLE_BIT = 5;
    localparam int REDUCE_DRIVE_LOWER_BIT = 4;
    localparam int PULLUP_EN_UPPER_BIT = 2;
    localparam int PULLUP_EN_MIDDLE_BIT = 1;
    localparam int PULLUP_EN_LOWER_BIT = 0;

    // serial control register fields
    localparam int SYNC_SERIAL_ENABLE_BIT = 0;
    localparam int WIRED_OR_MODE_BIT = 1;
    localparam int MASTER_SELECT_BIT = 2;
    localparam int SLAVE_SELECT_OUT_EN_BIT = 3;
    localparam int RX_TWO_WIRE_BIT = 4;
    localparam int TX_TWO_WIRE_BIT = 5;

    // pin groups
    localparam logic [7:0] PIN_GROUP_UPPER = 8'hF0;
    localparam logic [7:0] PIN_NOT_BONDED = 8'h0C;

    function automatic logic [ADR_W-1:0] idx_to_adr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : idx_to_adr

    // spread three group bits over the eight pins
    function automatic logic [7:0] group_expand(input logic upper, input logic middle,
                                                input logic lower);
        return {{4{upper}}, {2{middle}}, {2{lower}}};
    endfunction : group_expand
endpackage : spc_pkg

// File: spc_port_top.sv
// serial port pin control: data latch, direction, pull-up/drive and serial overrides
//
// Overview of operation
// RQ1: reset clears direction, all pins input
// RQ2: input pin reads back its pin level
// RQ3: output pin reads back its latch
// RQ4: writes never disturb serial-driven pins
// RQ5: direction bit 0 input, 1 output
// RQ6: two-wire receive forces receive pin input
// RQ7: two-wire transmit forces transmit pin output
// RQ8: pins 6..4 follow serial input needs
// RQ9: pins 6..4 serial outputs need direction set
// RQ10: slave mode: pin 7 always select input
// RQ11: master mode: bit 7 picks fault/output
// RQ12: three group bits reduce output drive
// RQ13: three group bits enable input pull-ups
// RQ14: pull-up off on any output pin
// RQ15: pins 3 and 2 not bonded out
// RQ16: serial enable dedicates pins 7..4
// RQ17: wired-or makes pins 7..4 open-drain
// RQ18: select output needs master, bit, enable
// RQ19: general outputs drive written latch value
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spc_port_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [spc_pkg::ADR_W-1:0] adr_i,
    input wire logic [spc_pkg::DAT_W-1:0] dat_i,
    output logic [spc_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    // serial units (same clock)
    input wire logic [7:4] spi_out_i,
    input wire logic [6:4] spi_out_need_i,
    input wire logic sci_txd_i,
    output logic [7:0] pin_level_o,
    // pads
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pullup_o,
    output logic [7:0] reduce_drive_o
);
    logic rd_req;
    logic wr;
    logic [7:0] pin_sync;
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] pull_drive_q;
    logic [7:0] ser_ctrl_q;
    logic [spc_pkg::DAT_W-1:0] dat_q;
    logic [7:0] eff_dir_q;
    logic [7:0] pin_o_q;
    logic [7:0] pin_oe_q;
    logic [7:0] pullup_q;
    logic [7:0] reduce_q;
    logic [7:0] eff_dir;
    logic [7:0] eff_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_out;
    logic [7:0] read_val;
    logic sync_serial_enable;
    logic wired_or_mode;
    logic master_select;
    logic slave_select_out_en;
    logic rx_two_wire;
    logic tx_two_wire;
    logic hit_data;
    logic hit_dir;
    logic hit_pull;
    logic hit_ser;

    spc_wb_if u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .sel0_i(sel_i[0]),
        .ack_o(ack_o),
        .rd_req_o(rd_req),
        .wr_o(wr)
    );

    spc_sync #(.WIDTH(8)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );

    assign hit_data = adr_i == spc_pkg::idx_to_adr(spc_pkg::IDX_PIN_DATA);
    assign hit_dir = adr_i == spc_pkg::idx_to_adr(spc_pkg::IDX_PIN_DIR);
    assign hit_pull = adr_i == spc_pkg::idx_to_adr(spc_pkg::IDX_PULL_DRIVE);
    assign hit_ser = adr_i == spc_pkg::idx_to_adr(spc_pkg::IDX_SERIAL_CTRL);

    assign sync_serial_enable = ser_ctrl_q[spc_pkg::SYNC_SERIAL_ENABLE_BIT];
    assign wired_or_mode = ser_ctrl_q[spc_pkg::WIRED_OR_MODE_BIT];
    assign master_select = ser_ctrl_q[spc_pkg::MASTER_SELECT_BIT];
    assign slave_select_out_en = ser_ctrl_q[spc_pkg::SLAVE_SELECT_OUT_EN_BIT];
    assign rx_two_wire = ser_ctrl_q[spc_pkg::RX_TWO_WIRE_BIT];
    assign tx_two_wire = ser_ctrl_q[spc_pkg::TX_TWO_WIRE_BIT];

    // latch always stores; pins owned by a serial unit ignore it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= spc_pkg::PIN_DATA_RST;
        end else if (wr && hit_data) begin
            latch_q <= dat_i[7:0]; // RQ4 RQ19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= spc_pkg::PIN_DIR_RST; // RQ1 RQ5
        end else if (wr && hit_dir) begin
            dir_q <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pull_drive_q <= spc_pkg::PULL_DRIVE_RST;
        end else if (wr && hit_pull) begin
            pull_drive_q <= dat_i[7:0] & spc_pkg::PULL_DRIVE_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ser_ctrl_q <= spc_pkg::SERIAL_CTRL_RST;
        end else if (wr && hit_ser) begin
            ser_ctrl_q <= dat_i[7:0] & spc_pkg::SERIAL_CTRL_MASK;
        end
    end

    // effective direction and source per pin
    always_comb begin
        eff_dir = dir_q; // RQ5
        eff_out = latch_q; // RQ19
        if (rx_two_wire) begin
            eff_dir[0] = 1'b0; // RQ6
        end
        if (tx_two_wire) begin
            eff_dir[1] = 1'b1; // RQ7
            eff_out[1] = sci_txd_i; // RQ4
        end
        if (sync_serial_enable) begin
            // RQ16
            for (int k = 4; k <= 6; k++) begin
                eff_dir[k] = spi_out_need_i[k] && dir_q[k]; // RQ8 RQ9
                eff_out[k] = spi_out_i[k];
            end
            if (!master_select) begin
                eff_dir[7] = 1'b0; // RQ10
            end else begin
                eff_dir[7] = dir_q[7]; // RQ11
                eff_out[7] = slave_select_out_en ? spi_out_i[7] : latch_q[7]; // RQ18
            end
        end
    end

    // wired-or: upper group only pulls low
    always_comb begin
        pad_oe = eff_dir;
        pad_out = eff_out;
        if (wired_or_mode) begin
            pad_oe = eff_dir & ~(eff_out & spc_pkg::PIN_GROUP_UPPER); // RQ17
            pad_out = eff_out & ~spc_pkg::PIN_GROUP_UPPER;
        end
    end

    // input pins show the pin, output pins the latch; unbonded inputs read 0
    assign read_val = (latch_q & eff_dir)
                    | (pin_sync & ~eff_dir & ~spc_pkg::PIN_NOT_BONDED); // RQ2 RQ3

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (rd_req) begin
            unique case (1'b1)
                hit_data: dat_q <= {24'h000000, read_val};
                hit_dir: dat_q <= {24'h000000, dir_q};
                hit_pull: dat_q <= {24'h000000, pull_drive_q};
                hit_ser: dat_q <= {24'h000000, ser_ctrl_q};
                default: dat_q <= '0;
            endcase
        end
    end

    assign dat_o = dat_q;

    // registered pad controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o_q <= 8'h00;
            pin_oe_q <= 8'h00; // RQ1
            eff_dir_q <= 8'h00;
            pullup_q <= 8'h00;
            reduce_q <= 8'h00;
        end else begin
            pin_o_q <= pad_out & ~spc_pkg::PIN_NOT_BONDED;
            pin_oe_q <= pad_oe & ~spc_pkg::PIN_NOT_BONDED; // RQ15
            eff_dir_q <= eff_dir;
            pullup_q <= spc_pkg::group_expand(pull_drive_q[spc_pkg::PULLUP_EN_UPPER_BIT],
                                              pull_drive_q[spc_pkg::PULLUP_EN_MIDDLE_BIT],
                                              pull_drive_q[spc_pkg::PULLUP_EN_LOWER_BIT])
                        & ~eff_dir; // RQ13 RQ14
            reduce_q <= spc_pkg::group_expand(pull_drive_q[spc_pkg::REDUCE_DRIVE_UPPER_BIT],
                                              pull_drive_q[spc_pkg::REDUCE_DRIVE_MIDDLE_BIT],
                                              pull_drive_q[spc_pkg::REDUCE_DRIVE_LOWER_BIT]); // RQ12
        end
    end

    assign pin_o = pin_o_q;
    assign pin_oe_o = pin_oe_q;
    assign pullup_o = pullup_q;
    assign reduce_drive_o = reduce_q;
    assign pin_level_o = pin_sync;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rst_inputs;
        @(posedge clk_i) disable iff (1'b0) rst_i |=> (dir_q == 8'h00) && (pin_oe_o == 8'h00);
    endproperty
    a_rst_inputs: assert property (p_rst_inputs) else $error("reset left a pin driven"); // RQ1

    property p_read_input;
        rd_req && hit_data |=> ((dat_o[7:0] ^ $past(pin_sync)) & ~$past(eff_dir)
                                & ~spc_pkg::PIN_NOT_BONDED) == 8'h00;
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read not pin level"); // RQ2

    property p_read_output;
        rd_req && hit_data |=> ((dat_o[7:0] ^ $past(latch_q)) & $past(eff_dir)) == 8'h00;
    endproperty
    a_read_output: assert property (p_read_output) else $error("output read not latch"); // RQ3

    property p_write_serial_pin;
        wr && hit_data && tx_two_wire ##1 tx_two_wire |=> pin_o[1] == $past(sci_txd_i);
    endproperty
    a_write_serial_pin: assert property (p_write_serial_pin) else $error("write moved tx pin"); // RQ4

    property p_dir_output;
        wr && hit_dir && !sync_serial_enable && !tx_two_wire && !rx_two_wire |=> ##1
            pin_oe_o[1:0] == $past(dat_i[1:0], 2) || wired_or_mode;
    endproperty
    a_dir_output: assert property (p_dir_output) else $error("direction not applied"); // RQ5

    property p_rx_input;
        rx_two_wire |=> !pin_oe_o[0];
    endproperty
    a_rx_input: assert property (p_rx_input) else $error("rx pin driven"); // RQ6

    property p_tx_output;
        tx_two_wire |=> pin_oe_o[1] && pin_o[1] == $past(sci_txd_i);
    endproperty
    a_tx_output: assert property (p_tx_output) else $error("tx pin not driven"); // RQ7

    property p_spi_in;
        sync_serial_enable |=> (pin_oe_o[6:4] & ~$past(spi_out_need_i)) == 3'b000;
    endproperty
    a_spi_in: assert property (p_spi_in) else $error("spi input pin driven"); // RQ8

    property p_spi_out_dir;
        sync_serial_enable |=> (pin_oe_o[6:4] & ~$past(dir_q[6:4])) == 3'b000;
    endproperty
    a_spi_out_dir: assert property (p_spi_out_dir) else $error("spi out without dir"); // RQ9

    property p_slave_select_in;
        sync_serial_enable && !master_select |=> !pin_oe_o[7];
    endproperty
    a_slave_select_in: assert property (p_slave_select_in) else $error("pin 7 driven slave"); // RQ10

    property p_ss_out;
        sync_serial_enable && master_select && dir_q[7] && slave_select_out_en && !wired_or_mode |=> pin_oe_o[7] && pin_o[7] == $past(spi_out_i[7]);
    endproperty
    a_ss_out: assert property (p_ss_out) else $error("select output missing"); // RQ18

    property p_pullup_off;
        (pullup_o & eff_dir_q) == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on output"); // RQ14

    property p_unbonded;
        pin_oe_o[3:2] == 2'b00;
    endproperty
    a_unbonded: assert property (p_unbonded) else $error("unbonded pin driven"); // RQ15

    property p_open_drain;
        wired_or_mode |=> (pin_oe_o[7:4] & pin_o[7:4]) == 4'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("upper pin drives high"); // RQ17

    property p_reduce;
        wr && hit_pull |=> ##1 reduce_drive_o[7:4] == {4{$past(dat_i[6], 2)}};
    endproperty
    a_reduce: assert property (p_reduce) else $error("reduced drive not applied"); // RQ12

    c_write_data: cover property (wr && hit_data ##2 pin_oe_o[0]);
    c_ss_out: cover property (sync_serial_enable && master_select && slave_select_out_en ##1 pin_oe_o[7]);
    c_tx_two_wire: cover property (tx_two_wire ##1 pin_oe_o[1]);
endmodule : spc_port_top
`default_nettype wire

// File: spc_port_top_tb.sv
// self-checking bench for the serial port pin control block
`timescale 1ns/1ns
`default_nettype none
module spc_port_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic [spc_pkg::ADR_W-1:0] adr_i = '0;
    logic [spc_pkg::DAT_W-1:0] dat_i = '0;
    logic [spc_pkg::DAT_W-1:0] dat_o;
    logic ack_o;
    logic [7:4] spi_out_i = 4'h0;
    logic [6:4] spi_out_need_i = 3'h0;
    logic sci_txd_i = 1'b0;
    logic [7:0] ext = 8'h00;
    logic [7:0] pin_level_o, pin_i, pin_o, pin_oe_o, pullup_o, reduce_drive_o;
    logic [31:0] seed = 32'h0000_0032;
    logic [31:0] rd;
    logic [7:0] ctl, dir, lat, pd, ed, src, oe, pu, pad;
    int fail_count = 0;
    int checks = 0;

    always #25 clk_i = ~clk_i;

    spc_port_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .spi_out_i(spi_out_i), .spi_out_need_i(spi_out_need_i),
        .sci_txd_i(sci_txd_i), .pin_level_o(pin_level_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .reduce_drive_o(reduce_drive_o));

    spc_pad_model i_pads (.drive_val_i(pin_o), .drive_en_i(pin_oe_o), .pullup_en_i(pullup_o),
        .ext_i(ext), .level_o(pin_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] sl);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= sl;
        adr_i <= {2'b00, idx, 2'b00};
        dat_i <= {24'h0, wd};
        // no limit on the wait for the answer; only the watchdog ends a wait where ack never comes
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end

    initial begin
        do_reset();
        @(negedge clk_i);
        chk(pin_oe_o, 8'h00);
        chk(pullup_o, 8'hFF);
        chk(reduce_drive_o, 8'h00);
        @(posedge clk_i);
        wb(1'b0, spc_pkg::IDX_PIN_DIR, 8'h00, 4'hF);
        chk(rd, 32'h0);
        wb(1'b0, spc_pkg::IDX_PULL_DRIVE, 8'h00, 4'hF);
        chk(rd, 32'h07);
        wb(1'b1, spc_pkg::IDX_PIN_DIR, 8'hFF, 4'hE);
        wb(1'b1, 8'h10, 8'hFF, 4'hF);
        wb(1'b0, 8'h10, 8'h00, 4'hF);
        chk(rd, 32'h0);
        wb(1'b0, spc_pkg::IDX_PIN_DIR, 8'h00, 4'hF);
        chk(rd, 32'h0);
        for (int i = 0; i < 200; i++) begin
            ctl = rnd() & 8'h3F;
            dir = rnd();
            lat = rnd();
            pd = rnd();
            rd = rnd();
            spi_out_i <= rd[7:4];
            spi_out_need_i <= rd[10:8];
            sci_txd_i <= rd[11];
            ext <= rd[23:16];
            wb(1'b1, spc_pkg::IDX_SERIAL_CTRL, ctl, 4'h1);
            wb(1'b1, spc_pkg::IDX_PIN_DIR, dir, 4'h1);
            wb(1'b1, spc_pkg::IDX_PIN_DATA, lat, 4'h1);
            wb(1'b1, spc_pkg::IDX_PULL_DRIVE, pd, 4'h1);
            repeat (6) @(posedge clk_i);
            ed = dir;
            src = lat;
            if (ctl[4]) ed[0] = 1'b0;
            if (ctl[5]) begin
                ed[1] = 1'b1;
                src[1] = sci_txd_i;
            end
            if (ctl[0]) begin
                for (int k = 4; k < 7; k++) begin
                    ed[k] = spi_out_need_i[k] & dir[k];
                    src[k] = spi_out_i[k];
                end
                ed[7] = ctl[2] & dir[7];
                if (ctl[2] & dir[7] & ctl[3]) src[7] = spi_out_i[7];
            end
            oe = ed & ~spc_pkg::PIN_NOT_BONDED;
            if (ctl[1]) oe[7:4] = oe[7:4] & ~src[7:4];
            pu = {{4{pd[2]}}, {2{pd[1]}}, {2{pd[0]}}} & ~ed;
            pad = (oe & src) | (~oe & pu) | (~oe & ~pu & ext);
            @(negedge clk_i);
            chk(pin_oe_o, oe);
            chk(pin_o & oe, src & oe);
            chk(pullup_o, pu);
            chk(reduce_drive_o, {{4{pd[6]}}, {2{pd[5]}}, {2{pd[4]}}});
            chk(pin_level_o, pad);
            @(posedge clk_i);
            wb(1'b0, spc_pkg::IDX_PIN_DATA, 8'h00, 4'hF);
            chk(rd, (ed & lat) | (~ed & pad & 8'hF3));
            wb(1'b0, spc_pkg::IDX_PIN_DIR, 8'h00, 4'hF);
            chk(rd, dir);
            wb(1'b0, spc_pkg::IDX_PULL_DRIVE, 8'h00, 4'hF);
            chk(rd, pd & 8'h77);
            wb(1'b0, spc_pkg::IDX_SERIAL_CTRL, 8'h00, 4'hF);
            chk(rd, ctl);
        end
        do_reset();
        @(negedge clk_i);
        chk(pin_oe_o, 8'h00);
        @(posedge clk_i);
        wb(1'b0, spc_pkg::IDX_PIN_DIR, 8'h00, 4'hF);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule : spc_port_top_tb
`default_nettype wire

// File: spc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module spc_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // async in, synchronised out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : spc_sync
`default_nettype wire

// File: spc_wb_if.sv
// classic wishbone single-cycle handshake for the register file
`timescale 1ns/1ns
`default_nettype none
module spc_wb_if (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus handshake
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic sel0_i,
    output logic ack_o,
    // strobes to the register file
    output logic rd_req_o,
    output logic wr_o
);
    logic ack_q;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    assign ack_o = ack_q;
    assign rd_req_o = cyc_i && stb_i && !we_i && !ack_q;
    // write lands on the edge where the master samples ack
    assign wr_o = cyc_i && stb_i && we_i && sel0_i && ack_q;
endmodule : spc_wb_if
`default_nettype wire
